//--- design/cpu8_core.sv
/*
 * Multicycle 8-bit accumulator/index core with its addressing unit.
 * Assumes memory answers a read in the same cycle that the read strobe is shown.
 */
// Operation
// - Sixty-two instructions over nine addressing modes
// - Multiply A by X; high to X
// - Inherent: one byte, no operand address
// - Immediate: two bytes, second is data
// - Direct: two bytes, high address zero
// - Extended: three bytes, high then low
// - Indexed no offset: one byte, address X
// - Indexed 8-bit offset: X plus byte, nine-bit
// - Indexed 16-bit offset: X plus word
// - Relative: next address plus signed offset
// - Read-modify-write writes result back in place
// - Bit set and clear use direct only
// - Test negative-zero never writes back
// - Bit branch: three bytes, bit in opcode
// - Bit branch copies tested bit to carry
// - Bit set/clear reach first 256 bytes
// - Branches on interrupt pin level high/low
// - Stop and wait clear interrupt mask
`timescale 1ns/100ps
module cpu8_core
	import cpu8_pkg::*;
#(
	parameter logic [15:0] RESET_VECTOR = RESET_VEC,
	parameter logic [15:0] SWI_VECTOR   = SWI_VEC
) (
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	input  wire logic        irq_n_in,
	input  wire logic        periph_irq_in,
	input  wire logic [7:0]  mem_rdata_in,
	output logic      [15:0] mem_addr_out,
	output logic             mem_rd_out,
	output logic             mem_wr_out,
	output logic      [7:0]  mem_wdata_out,
	output logic             opfetch_out,
	output logic             stop_out,
	output logic             wait_out
);
	typedef enum logic [13:0] {
		ST_FETCH = 14'h0001,
		ST_DEC   = 14'h0002,
		ST_OPB1  = 14'h0004,
		ST_OPB2  = 14'h0008,
		ST_EXEC  = 14'h0010,
		ST_ALU   = 14'h0020,
		ST_PUSH  = 14'h0040,
		ST_PULL  = 14'h0080,
		ST_PULLD = 14'h0100,
		ST_RSTV  = 14'h0200,
		ST_VECH  = 14'h0400,
		ST_VECL  = 14'h0800,
		ST_STOP  = 14'h1000,
		ST_WAIT  = 14'h2000
	} state_t;

	typedef struct packed {
		state_t      st;
		logic [15:0] pc;
		logic [7:0]  a;
		logic [7:0]  x;
		logic [7:0]  sp;
		logic [7:0]  op;
		logic [7:0]  b1;
		logic [7:0]  b2;
		logic [15:0] ea;
		logic        h;
		logic        i;
		logic        n;
		logic        z;
		logic        c;
		logic [2:0]  cnt;
		logic [2:0]  plast;
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic        opf;
		logic [7:0]  wd;
		logic        stp;
		logic        wt;
		logic        irq_m;
		logic        irq_s;
	} core_t;

	core_t       s_r;
	core_t       s_nxt;
	logic [7:0]  dec_op;
	logic [3:0]  mode;
	logic [2:0]  cls;
	logic [1:0]  len;
	logic [15:0] ea_calc;
	logic [7:0]  rel_off;
	logic [15:0] br_tgt;
	logic        br_base;
	logic [7:0]  opv;
	logic [7:0]  lhs;
	logic [7:0]  res;
	logic [8:0]  sum9;
	logic [8:0]  dif9;
	logic [4:0]  hsum;
	logic        cin;
	logic        cres;
	logic        bitv;
	logic [15:0] prod;
	logic [15:0] vtgt;

	assign dec_op = (s_r.st == ST_DEC) ? mem_rdata_in : s_r.op;

	cpu8_decode u_decode (
		.op_in     (dec_op),
		.mode_out  (mode),
		.class_out (cls),
		.len_out   (len)
	);

	// Effective address per addressing mode
	always_comb begin
		case (mode)
			M_DIR, M_BTB: ea_calc = {ZERO_PAGE, s_r.b1};
			M_EXT: ea_calc = {s_r.b1, s_r.b2};
			M_IX: ea_calc = {ZERO_PAGE, s_r.x};
			M_IX1: ea_calc = {7'h00, {1'b0, s_r.x} + {1'b0, s_r.b1}};
			M_IX2: ea_calc = {s_r.b1, s_r.b2} + {ZERO_PAGE, s_r.x};
			default: ea_calc = s_r.ea;
		endcase
	end

	assign rel_off = (mode == M_BTB) ? s_r.b2 : s_r.b1;
	assign br_tgt = s_r.pc + {{8{rel_off[7]}}, rel_off};

	// Pair condition; the odd opcode of each pair inverts it
	always_comb begin
		case (s_r.op[3:1])
			3'h0: br_base = 1'b1;
			3'h1: br_base = ~(s_r.c | s_r.z);
			3'h2: br_base = ~s_r.c;
			3'h3: br_base = ~s_r.z;
			3'h4: br_base = ~s_r.h;
			3'h5: br_base = ~s_r.n;
			3'h6: br_base = ~s_r.i;
			default: br_base = ~s_r.irq_s;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.rd = 1'b0;
		s_nxt.wr = 1'b0;
		s_nxt.opf = 1'b0;
		s_nxt.irq_m = irq_n_in;
		s_nxt.irq_s = s_r.irq_m;
		opv = (mode == M_IMM) ? s_r.b1 : mem_rdata_in;
		lhs = (s_r.op[3:0] == RM_CPX) ? s_r.x : s_r.a;
		cin = (s_r.op[3:0] == RM_SBC || s_r.op[3:0] == RM_ADC) ? s_r.c : 1'b0;
		sum9 = {1'b0, s_r.a} + {1'b0, opv} + {8'h00, cin};
		dif9 = {1'b0, lhs} - {1'b0, opv} - {8'h00, cin};
		hsum = {1'b0, s_r.a[3:0]} + {1'b0, opv[3:0]} + {4'h0, cin};
		res = s_r.a;
		cres = s_r.c;
		bitv = mem_rdata_in[s_r.op[3:1]];
		prod = s_r.a * s_r.x;
		vtgt = {s_r.b1, mem_rdata_in};
		case (s_r.st)
			ST_FETCH: begin
				s_nxt.addr = s_r.pc;
				s_nxt.rd = 1'b1;
				s_nxt.opf = 1'b1;
				s_nxt.pc = s_r.pc + 16'h0001;
				s_nxt.st = ST_DEC;
			end
			ST_DEC: begin
				s_nxt.op = mem_rdata_in;
				if (len != LEN1) begin
					s_nxt.addr = s_r.pc;
					s_nxt.rd = 1'b1;
					s_nxt.pc = s_r.pc + 16'h0001;
					s_nxt.st = ST_OPB1;
				end else begin
					s_nxt.st = ST_EXEC;
				end
			end
			ST_OPB1: begin
				s_nxt.b1 = mem_rdata_in;
				if (len == LEN3) begin
					s_nxt.addr = s_r.pc;
					s_nxt.rd = 1'b1;
					s_nxt.pc = s_r.pc + 16'h0001;
					s_nxt.st = ST_OPB2;
				end else begin
					s_nxt.st = ST_EXEC;
				end
			end
			ST_OPB2: begin
				s_nxt.b2 = mem_rdata_in;
				s_nxt.st = ST_EXEC;
			end
			ST_EXEC: begin
				s_nxt.ea = ea_calc;
				s_nxt.addr = ea_calc;
				s_nxt.st = ST_ALU;
				case (cls)
					C_BR: begin
						if (br_base ^ s_r.op[0])
							s_nxt.pc = br_tgt;
						s_nxt.st = ST_FETCH;
					end
					C_BTB, C_BSC: s_nxt.rd = 1'b1;
					C_RMW: s_nxt.rd = (mode != M_INH);
					C_RM: begin
						case (s_r.op[3:0])
							RM_STA, RM_STX: begin
								res = (s_r.op[3:0] == RM_STA) ? s_r.a : s_r.x;
								s_nxt.wr = 1'b1;
								s_nxt.wd = res;
								s_nxt.n = res[7];
								s_nxt.z = (res == 8'h00);
								s_nxt.st = ST_FETCH;
							end
							RM_JMP: begin
								s_nxt.pc = ea_calc;
								s_nxt.st = ST_FETCH;
							end
							RM_JSR: begin
								s_nxt.ea = (mode == M_REL) ? br_tgt : ea_calc;
								s_nxt.cnt = 3'h0;
								s_nxt.plast = LAST_SUB;
								s_nxt.st = ST_PUSH;
							end
							default: s_nxt.rd = (mode != M_IMM);
						endcase
					end
					default: s_nxt.st = ST_ALU;
				endcase
			end
			ST_ALU: begin
				s_nxt.st = ST_FETCH;
				case (cls)
					C_RM: begin
						case (s_r.op[3:0])
							RM_SUB, RM_CMP, RM_SBC, RM_CPX: begin
								res = dif9[7:0];
								s_nxt.c = dif9[8];
							end
							RM_AND, RM_BIT: res = s_r.a & opv;
							RM_EOR: res = s_r.a ^ opv;
							RM_ORA: res = s_r.a | opv;
							RM_ADC, RM_ADD: begin
								res = sum9[7:0];
								s_nxt.c = sum9[8];
								s_nxt.h = hsum[4];
							end
							default: res = opv;
						endcase
						s_nxt.n = res[7];
						s_nxt.z = (res == 8'h00);
						if (s_r.op[3:0] == RM_LDX)
							s_nxt.x = res;
						else if (s_r.op[3:0] != RM_CMP && s_r.op[3:0] != RM_CPX && s_r.op[3:0] != RM_BIT)
							s_nxt.a = res;
					end
					C_RMW: begin
						opv = (mode != M_INH) ? mem_rdata_in : (s_r.op[4] ? s_r.x : s_r.a);
						case (s_r.op[3:0])
							MW_NEG: begin
								res = 8'h00 - opv;
								cres = (res != 8'h00);
							end
							MW_COM: begin
								res = ~opv;
								cres = 1'b1;
							end
							MW_LSR: {res, cres} = {1'b0, opv};
							MW_ROR: {res, cres} = {s_r.c, opv};
							MW_ASR: {res, cres} = {opv[7], opv};
							MW_LSL: {cres, res} = {opv, 1'b0};
							MW_ROL: {cres, res} = {opv, s_r.c};
							MW_DEC: res = opv - 8'h01;
							MW_INC: res = opv + 8'h01;
							MW_CLR: res = 8'h00;
							default: res = opv;
						endcase
						s_nxt.c = cres;
						s_nxt.n = res[7];
						s_nxt.z = (res == 8'h00);
						if (s_r.op[3:0] != MW_TEST_NZ) begin
							if (mode != M_INH) begin
								s_nxt.wr = 1'b1;
								s_nxt.wd = res;
							end else if (s_r.op[4])
								s_nxt.x = res;
							else
								s_nxt.a = res;
						end
					end
					C_BTB: begin
						s_nxt.c = bitv;
						if (bitv ^ s_r.op[0])
							s_nxt.pc = br_tgt;
					end
					C_BSC: begin
						res = mem_rdata_in;
						res[s_r.op[3:1]] = ~s_r.op[0];
						s_nxt.wr = 1'b1;
						s_nxt.wd = res;
					end
					C_UMULT: begin
						{s_nxt.x, s_nxt.a} = prod;
						s_nxt.h = 1'b0;
						s_nxt.c = 1'b0;
					end
					default: begin
						case (s_r.op)
							OP_RTI: begin
								s_nxt.cnt = LAST_SWI;
								s_nxt.st = ST_PULL;
							end
							OP_RTS: begin
								s_nxt.cnt = LAST_SUB;
								s_nxt.st = ST_PULL;
							end
							OP_SWI: begin
								s_nxt.ea = SWI_VECTOR;
								s_nxt.cnt = 3'h0;
								s_nxt.plast = LAST_SWI;
								s_nxt.st = ST_PUSH;
							end
							OP_STOP: begin
								s_nxt.i = 1'b0;
								s_nxt.stp = 1'b1;
								s_nxt.st = ST_STOP;
							end
							OP_WAIT: begin
								s_nxt.i = 1'b0;
								s_nxt.wt = 1'b1;
								s_nxt.st = ST_WAIT;
							end
							OP_TAX: s_nxt.x = s_r.a;
							OP_TXA: s_nxt.a = s_r.x;
							OP_CLC: s_nxt.c = 1'b0;
							OP_SEC: s_nxt.c = 1'b1;
							OP_CLI: s_nxt.i = 1'b0;
							OP_SEI: s_nxt.i = 1'b1;
							OP_RSP: s_nxt.sp = STACK_TOP;
							default: s_nxt.st = ST_FETCH;
						endcase
					end
				endcase
			end
			ST_PUSH: begin
				s_nxt.addr = {ZERO_PAGE, s_r.sp};
				s_nxt.wr = 1'b1;
				case (s_r.cnt)
					3'h0: s_nxt.wd = s_r.pc[7:0];
					3'h1: s_nxt.wd = s_r.pc[15:8];
					3'h2: s_nxt.wd = s_r.x;
					3'h3: s_nxt.wd = s_r.a;
					default: s_nxt.wd = {CCR_PAD, s_r.h, s_r.i, s_r.n, s_r.z, s_r.c};
				endcase
				s_nxt.sp = s_r.sp - 8'h01;
				s_nxt.cnt = s_r.cnt + 3'h1;
				if (s_r.cnt == s_r.plast) begin
					if (s_r.op == OP_SWI) begin
						s_nxt.i = 1'b1;
						s_nxt.st = ST_RSTV;
					end else begin
						s_nxt.pc = s_r.ea;
						s_nxt.st = ST_FETCH;
					end
				end
			end
			ST_PULL, ST_PULLD: begin
				if (s_r.st == ST_PULLD) begin
					case (s_r.cnt)
						3'h0: s_nxt.pc[7:0] = mem_rdata_in;
						3'h1: s_nxt.pc[15:8] = mem_rdata_in;
						3'h2: s_nxt.x = mem_rdata_in;
						3'h3: s_nxt.a = mem_rdata_in;
						default: {s_nxt.h, s_nxt.i, s_nxt.n, s_nxt.z, s_nxt.c} = mem_rdata_in[4:0];
					endcase
					s_nxt.cnt = s_r.cnt - 3'h1;
				end
				if (s_r.st == ST_PULLD && s_r.cnt == 3'h0) begin
					s_nxt.st = ST_FETCH;
				end else begin
					s_nxt.sp = s_r.sp + 8'h01;
					s_nxt.addr = {ZERO_PAGE, s_r.sp + 8'h01};
					s_nxt.rd = 1'b1;
					s_nxt.st = ST_PULLD;
				end
			end
			ST_RSTV: begin
				s_nxt.addr = s_r.ea;
				s_nxt.rd = 1'b1;
				s_nxt.st = ST_VECH;
			end
			ST_VECH: begin
				s_nxt.b1 = mem_rdata_in;
				s_nxt.addr = s_r.ea + 16'h0001;
				s_nxt.rd = 1'b1;
				s_nxt.st = ST_VECL;
			end
			ST_VECL: begin
				s_nxt.addr = vtgt;
				s_nxt.rd = 1'b1;
				s_nxt.opf = 1'b1;
				s_nxt.pc = vtgt + 16'h0001;
				s_nxt.st = ST_DEC;
			end
			ST_STOP: begin
				if (!s_r.irq_s) begin
					s_nxt.stp = 1'b0;
					s_nxt.st = ST_FETCH;
				end
			end
			ST_WAIT: begin
				if (!s_r.irq_s || periph_irq_in) begin
					s_nxt.wt = 1'b0;
					s_nxt.st = ST_FETCH;
				end
			end
			default: s_nxt.st = ST_FETCH;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_r <= '0;
			s_r.st <= ST_RSTV;
			s_r.ea <= RESET_VECTOR;
			s_r.sp <= STACK_TOP;
			s_r.i <= 1'b1;
			s_r.irq_m <= 1'b1;
			s_r.irq_s <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign mem_addr_out = s_r.addr;
	assign mem_rd_out = s_r.rd;
	assign mem_wr_out = s_r.wr;
	assign mem_wdata_out = s_r.wd;
	assign opfetch_out = s_r.opf;
	assign stop_out = s_r.stp;
	assign wait_out = s_r.wt;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!reset_n_in);

	product_split_a: assert property (s_r.st == ST_ALU && cls == C_UMULT
		|=> {s_r.x, s_r.a} == $past(s_r.a) * $past(s_r.x)) else $error("bad product");
	inh_len_a: assert property (s_r.st == ST_DEC && len == LEN1
		|=> s_r.st == ST_EXEC && !mem_rd_out && s_r.pc == $past(s_r.pc)) else $error("inherent fetched operand");
	dir_ea_a: assert property (s_r.st == ST_EXEC && mode == M_DIR && s_nxt.rd
		|=> mem_addr_out == {ZERO_PAGE, $past(s_r.b1)}) else $error("direct address wrong");
	ext_ea_a: assert property (s_r.st == ST_EXEC && mode == M_EXT && s_nxt.rd
		|=> mem_addr_out == {$past(s_r.b1), $past(s_r.b2)}) else $error("extended address wrong");
	ix1_ea_a: assert property (s_r.st == ST_EXEC && mode == M_IX1 && s_nxt.rd
		|=> mem_addr_out == {7'h00, {1'b0, $past(s_r.x)} + {1'b0, $past(s_r.b1)}}) else $error("ix1 address wrong");
	rmw_back_a: assert property (s_r.st == ST_EXEC && cls == C_RMW && mode != M_INH
		&& s_r.op[3:0] != MW_TEST_NZ |=> ##1 mem_wr_out && mem_addr_out == $past(s_r.ea)) else $error("no write back");
	test_nowrite_a: assert property (s_r.st == ST_ALU && cls == C_RMW && s_r.op[3:0] == MW_TEST_NZ
		|=> !mem_wr_out) else $error("test wrote back");
	btb_carry_a: assert property (s_r.st == ST_ALU && cls == C_BTB
		|=> s_r.c == $past(mem_rdata_in[s_r.op[3:1]])) else $error("carry not bit");
	rel_take_a: assert property (s_r.st == ST_EXEC && cls == C_BR && (br_base ^ s_r.op[0])
		|=> s_r.pc == $past(s_r.pc) + {{8{$past(s_r.b1[7])}}, $past(s_r.b1)}) else $error("branch target wrong");
	stop_mask_a: assert property (s_r.st == ST_ALU && s_r.op == OP_STOP && cls == C_CTL
		|=> stop_out && !s_r.i) else $error("stop not entered");
endmodule // cpu8_core

//--- design/cpu8_pkg.sv
/*
 * Constants shared by the 8-bit core and its opcode decoder.
 * Assumes the standard opcode map of this core family.
 */
package cpu8_pkg;
	// Addressing modes
	localparam logic [3:0] M_INH = 4'h0;
	localparam logic [3:0] M_IMM = 4'h1;
	localparam logic [3:0] M_DIR = 4'h2;
	localparam logic [3:0] M_EXT = 4'h3;
	localparam logic [3:0] M_IX  = 4'h4;
	localparam logic [3:0] M_IX1 = 4'h5;
	localparam logic [3:0] M_IX2 = 4'h6;
	localparam logic [3:0] M_REL = 4'h7;
	localparam logic [3:0] M_BTB = 4'h8;
	// Instruction classes
	localparam logic [2:0] C_BTB = 3'h0;
	localparam logic [2:0] C_BSC = 3'h1;
	localparam logic [2:0] C_BR  = 3'h2;
	localparam logic [2:0] C_RMW = 3'h3;
	localparam logic [2:0] C_CTL = 3'h4;
	localparam logic [2:0] C_RM  = 3'h5;
	localparam logic [2:0] C_UMULT = 3'h6;
	// Instruction lengths in bytes
	localparam logic [1:0] LEN1 = 2'h1;
	localparam logic [1:0] LEN2 = 2'h2;
	localparam logic [1:0] LEN3 = 2'h3;
	// Single opcodes
	localparam logic [7:0] OP_UMULT = 8'h42;
	localparam logic [7:0] OP_RTI  = 8'h80;
	localparam logic [7:0] OP_RTS  = 8'h81;
	localparam logic [7:0] OP_SWI  = 8'h83;
	localparam logic [7:0] OP_STOP = 8'h8E;
	localparam logic [7:0] OP_WAIT = 8'h8F;
	localparam logic [7:0] OP_TAX  = 8'h97;
	localparam logic [7:0] OP_CLC  = 8'h98;
	localparam logic [7:0] OP_SEC  = 8'h99;
	localparam logic [7:0] OP_CLI  = 8'h9A;
	localparam logic [7:0] OP_SEI  = 8'h9B;
	localparam logic [7:0] OP_RSP  = 8'h9C;
	localparam logic [7:0] OP_TXA  = 8'h9F;
	localparam logic [7:0] OP_BSR  = 8'hAD;
	// Register/memory low nibbles
	localparam logic [3:0] RM_SUB = 4'h0;
	localparam logic [3:0] RM_CMP = 4'h1;
	localparam logic [3:0] RM_SBC = 4'h2;
	localparam logic [3:0] RM_CPX = 4'h3;
	localparam logic [3:0] RM_AND = 4'h4;
	localparam logic [3:0] RM_BIT = 4'h5;
	localparam logic [3:0] RM_LDA = 4'h6;
	localparam logic [3:0] RM_STA = 4'h7;
	localparam logic [3:0] RM_EOR = 4'h8;
	localparam logic [3:0] RM_ADC = 4'h9;
	localparam logic [3:0] RM_ORA = 4'hA;
	localparam logic [3:0] RM_ADD = 4'hB;
	localparam logic [3:0] RM_JMP = 4'hC;
	localparam logic [3:0] RM_JSR = 4'hD;
	localparam logic [3:0] RM_LDX = 4'hE;
	localparam logic [3:0] RM_STX = 4'hF;
	// Read-modify-write low nibbles
	localparam logic [3:0] MW_NEG = 4'h0;
	localparam logic [3:0] MW_COM = 4'h3;
	localparam logic [3:0] MW_LSR = 4'h4;
	localparam logic [3:0] MW_ROR = 4'h6;
	localparam logic [3:0] MW_ASR = 4'h7;
	localparam logic [3:0] MW_LSL = 4'h8;
	localparam logic [3:0] MW_ROL = 4'h9;
	localparam logic [3:0] MW_DEC = 4'hA;
	localparam logic [3:0] MW_INC = 4'hC;
	localparam logic [3:0] MW_TEST_NZ = 4'hD;
	localparam logic [3:0] MW_CLR = 4'hF;
	// Stack and reset
	localparam logic [7:0]  STACK_TOP  = 8'hFF;
	localparam logic [7:0]  ZERO_PAGE  = 8'h00;
	localparam logic [2:0]  CCR_PAD    = 3'h7;
	localparam logic [2:0]  LAST_SUB   = 3'h1;
	localparam logic [2:0]  LAST_SWI   = 3'h4;
	localparam logic [15:0] RESET_VEC  = 16'hFFFE;
	localparam logic [15:0] SWI_VEC    = 16'hFFFC;
endpackage

//--- design/cpu8_decode.sv
/*
 * Opcode decoder: addressing mode, class and byte length of an opcode.
 * Assumes the opcode map of this core family; unused codes in rows 8 and 9 fall to control no-ops.
 */
`timescale 1ns/100ps
module cpu8_decode
	import cpu8_pkg::*;
(
	input  wire logic [7:0] op_in,
	output logic      [3:0] mode_out,
	output logic      [2:0] class_out,
	output logic      [1:0] len_out
);
	always_comb begin
		mode_out = M_INH;
		class_out = C_CTL;
		case (op_in[7:4])
			4'h0: begin
				mode_out = M_BTB;
				class_out = C_BTB;
			end
			4'h1: begin
				mode_out = M_DIR;
				class_out = C_BSC;
			end
			4'h2: begin
				mode_out = M_REL;
				class_out = C_BR;
			end
			4'h3: begin
				mode_out = M_DIR;
				class_out = C_RMW;
			end
			4'h4, 4'h5: begin
				mode_out = M_INH;
				class_out = (op_in == OP_UMULT) ? C_UMULT : C_RMW;
			end
			4'h6: begin
				mode_out = M_IX1;
				class_out = C_RMW;
			end
			4'h7: begin
				mode_out = M_IX;
				class_out = C_RMW;
			end
			4'hA: begin
				mode_out = (op_in == OP_BSR) ? M_REL : M_IMM;
				class_out = C_RM;
			end
			4'hB: begin
				mode_out = M_DIR;
				class_out = C_RM;
			end
			4'hC: begin
				mode_out = M_EXT;
				class_out = C_RM;
			end
			4'hD: begin
				mode_out = M_IX2;
				class_out = C_RM;
			end
			4'hE: begin
				mode_out = M_IX1;
				class_out = C_RM;
			end
			4'hF: begin
				mode_out = M_IX;
				class_out = C_RM;
			end
			default: begin
				mode_out = M_INH;
				class_out = C_CTL;
			end
		endcase
		case (mode_out)
			M_INH, M_IX: len_out = LEN1;
			M_EXT, M_IX2, M_BTB: len_out = LEN3;
			default: len_out = LEN2;
		endcase
	end
endmodule // cpu8_decode

//--- verification/mem_model.sv
/*
 * Zero-wait on-chip memory and I/O space seen by the core.
 * Assumes reads are answered in the cycle of the strobe; writes are logged for the bench.
 */
`timescale 1ns/100ps
module mem_model (
	input  wire logic        clk_sys_in,
	input  wire logic [15:0] mem_addr_in,
	input  wire logic        mem_rd_in,
	input  wire logic        mem_wr_in,
	input  wire logic [7:0]  mem_wdata_in,
	output logic      [7:0]  mem_rdata_out
);
	logic [7:0]  mem_q [0:65535];
	logic [7:0]  last_q;
	logic [15:0] wr_addr_q [$];
	logic [7:0]  wr_data_q [$];

	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem_q[i] = 8'h9D;
		end
		mem_q[16'hFFFE] = 8'h02;
		mem_q[16'hFFFF] = 8'h00;
		last_q = 8'h00;
	end

	// Bus not read shows the complement of the last byte read, not that byte itself
	assign mem_rdata_out = mem_rd_in ? mem_q[mem_addr_in] : ~last_q;

	always @(posedge clk_sys_in) begin
		if (mem_rd_in) begin
			last_q <= mem_q[mem_addr_in];
		end
		if (mem_wr_in) begin
			mem_q[mem_addr_in] <= mem_wdata_in;
			wr_addr_q.push_back(mem_addr_in);
			wr_data_q.push_back(mem_wdata_in);
		end
	end
endmodule // mem_model

//--- verification/testbench.sv
/*
 * Self-checking bench: runs short programs on the core and judges its memory writes.
 * Assumes the memory model holds the reset vector pointing at 0200.
 */
`timescale 1ns/100ps
module testbench;
	logic        clk_sys_in;
	logic        reset_n_in;
	logic        irq_n_in;
	logic        periph_irq_in;
	logic [7:0]  mem_rdata_in;
	logic [15:0] mem_addr_out;
	logic        mem_rd_out;
	logic        mem_wr_out;
	logic [7:0]  mem_wdata_out;
	logic        opfetch_out;
	logic        stop_out;
	logic        wait_out;
	int          bad_count;
	int          n_checks;

	cpu8_core dut (
		.clk_sys_in    (clk_sys_in),
		.reset_n_in    (reset_n_in),
		.irq_n_in      (irq_n_in),
		.periph_irq_in (periph_irq_in),
		.mem_rdata_in  (mem_rdata_in),
		.mem_addr_out  (mem_addr_out),
		.mem_rd_out    (mem_rd_out),
		.mem_wr_out    (mem_wr_out),
		.mem_wdata_out (mem_wdata_out),
		.opfetch_out   (opfetch_out),
		.stop_out      (stop_out),
		.wait_out      (wait_out)
	);

	mem_model memory (
		.clk_sys_in    (clk_sys_in),
		.mem_addr_in   (mem_addr_out),
		.mem_rd_in     (mem_rd_out),
		.mem_wr_in     (mem_wr_out),
		.mem_wdata_in  (mem_wdata_out),
		.mem_rdata_out (mem_rdata_in)
	);

	initial clk_sys_in = 1'b0;
	always #4 clk_sys_in = ~clk_sys_in;

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk_wr(input int idx, input logic [15:0] ea, input logic [7:0] ed);
		logic [15:0] ga;
		logic [7:0]  gd;
		ga = memory.wr_addr_q.size() > idx ? memory.wr_addr_q[idx] : 16'hXXXX;
		gd = memory.wr_data_q.size() > idx ? memory.wr_data_q[idx] : 8'hXX;
		n_checks++;
		if (ga !== ea || gd !== ed) begin
			bad_count++;
			$display("wrong value write %0d exp %h=%h got %h=%h", idx, ea, ed, ga, gd);
		end
	endtask

	task automatic chk_bit(input string name, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s exp %b got %b", name, e, g);
		end
	endtask

	// Program at 0200 ending in a jump to itself
	task automatic load(input logic [7:0] code [$]);
		int n;
		n = code.size();
		foreach (code[i]) memory.mem_q[16'h0200 + i] = code[i];
		memory.mem_q[16'h0200 + n] = 8'hCC;
		memory.mem_q[16'h0201 + n] = 8'h02;
		memory.mem_q[16'h0202 + n] = 8'(n);
	endtask

	task automatic rst();
		@(posedge clk_sys_in);
		reset_n_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		memory.wr_addr_q.delete();
		memory.wr_data_q.delete();
		reset_n_in <= 1'b1;
	endtask

	task automatic wait_wr(input int n);
		int t;
		t = 0;
		while (memory.wr_addr_q.size() < n && t < 3000) begin
			@(posedge clk_sys_in);
			t++;
		end
		#1;
	endtask

	task automatic t_mul();
		load('{8'hA6, 8'hC8, 8'hAE, 8'hF3, 8'h42, 8'hB7, 8'h80, 8'hBF, 8'h81});
		rst();
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk_bit("opcode fetch", 1'b0, opfetch_out);
		@(posedge clk_sys_in);
		#1;
		chk_bit("opcode fetch", 1'b1, opfetch_out && mem_addr_out == 16'h0200);
		wait_wr(2);
		chk_wr(0, 16'h0080, 8'hD8);
		chk_wr(1, 16'h0081, 8'hBD);
	endtask

	task automatic t_modes();
		memory.mem_q[16'h00F0] = 8'h11;
		memory.mem_q[16'h1324] = 8'h33;
		memory.mem_q[16'h01FE] = 8'h22;
		memory.mem_q[16'h4567] = 8'h44;
		load('{8'hAE, 8'hF0, 8'hF6, 8'hB7, 8'h82, 8'hD6, 8'h12, 8'h34, 8'hB7, 8'h83,
			8'hAE, 8'hFF, 8'hE6, 8'hFF, 8'hB7, 8'h84, 8'hC6, 8'h45, 8'h67, 8'hC7, 8'h34, 8'h56});
		rst();
		wait_wr(4);
		chk_wr(0, 16'h0082, 8'h11);
		chk_wr(1, 16'h0083, 8'h33);
		chk_wr(2, 16'h0084, 8'h22);
		chk_wr(3, 16'h3456, 8'h44);
	endtask

	task automatic t_rmw();
		memory.mem_q[16'h0090] = 8'h7F;
		memory.mem_q[16'h0091] = 8'h00;
		load('{8'h3C, 8'h90, 8'h3D, 8'h91, 8'hA6, 8'h5A, 8'h20, 8'h04,
			8'hB7, 8'h92, 8'h20, 8'h02, 8'h20, 8'hFA});
		rst();
		wait_wr(2);
		chk_wr(0, 16'h0090, 8'h80);
		chk_wr(1, 16'h0092, 8'h5A);
	endtask

	task automatic t_bits();
		memory.mem_q[16'h00A0] = 8'h00;
		memory.mem_q[16'h00A1] = 8'hFF;
		memory.mem_q[16'h00A2] = 8'h01;
		load('{8'h16, 8'hA0, 8'h1F, 8'hA1, 8'hA6, 8'h11, 8'h00, 8'hA2, 8'h02, 8'hA6, 8'hEE,
			8'hB7, 8'hB0, 8'h4F, 8'h49, 8'hB7, 8'hB1, 8'h99, 8'h02, 8'hA2, 8'h02,
			8'hA6, 8'h22, 8'hB7, 8'hB2, 8'h4F, 8'h49, 8'hB7, 8'hB3});
		rst();
		wait_wr(6);
		chk_wr(0, 16'h00A0, 8'h08);
		chk_wr(1, 16'h00A1, 8'h7F);
		chk_wr(2, 16'h00B0, 8'h11);
		chk_wr(3, 16'h00B1, 8'h01);
		chk_wr(4, 16'h00B2, 8'h22);
		chk_wr(5, 16'h00B3, 8'h00);
	endtask

	// Call, return and software trap with their stack frames
	task automatic t_sub();
		memory.mem_q[cpu8_pkg::SWI_VEC] = 8'h02;
		memory.mem_q[cpu8_pkg::SWI_VEC + 16'h0001] = 8'h0D;
		load('{8'hA6, 8'h5C, 8'hAD, 8'h07, 8'hB7, 8'hE1, 8'h83, 8'hB7, 8'hE2, 8'h20, 8'h04,
			8'h4C, 8'h81, 8'h4C, 8'h80});
		rst();
		wait_wr(9);
		chk_wr(0, 16'h00FF, 8'h04);
		chk_wr(1, 16'h00FE, 8'h02);
		chk_wr(2, 16'h00E1, 8'h5D);
		chk_wr(3, 16'h00FF, 8'h07);
		chk_wr(5, 16'h00FD, 8'h00);
		chk_wr(6, 16'h00FC, 8'h5D);
		chk_wr(8, 16'h00E2, 8'h5D);
	endtask

	task automatic t_pin();
		logic [7:0] exp [2];
		exp = '{8'h77, 8'hEE};
		load('{8'h2F, 8'h02, 8'hA6, 8'hEE, 8'h2E, 8'h02, 8'hA6, 8'h77, 8'hB7, 8'hC0});
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_sys_in);
			irq_n_in <= (i == 0);
			rst();
			wait_wr(1);
			chk_wr(0, 16'h00C0, exp[i]);
		end
		@(posedge clk_sys_in);
		irq_n_in <= 1'b1;
	endtask

	task automatic t_halt();
		int t;
		for (int i = 0; i < 2; i++) begin
			load('{8'hA6, 8'h44, (i == 0) ? 8'h8E : 8'h8F, 8'h2C, 8'h02, 8'hA6, 8'hEE, 8'hB7, 8'hD0});
			rst();
			t = 0;
			while (!(i == 0 ? stop_out : wait_out) && t < 300) begin
				@(posedge clk_sys_in);
				t++;
			end
			#1;
			chk_bit("halt flag", 1'b1, i == 0 ? stop_out : wait_out);
			@(posedge clk_sys_in);
			irq_n_in <= (i != 0);
			periph_irq_in <= (i != 0);
			repeat (4) @(posedge clk_sys_in);
			irq_n_in <= 1'b1;
			periph_irq_in <= 1'b0;
			wait_wr(1);
			chk_bit("halt flag", 1'b0, i == 0 ? stop_out : wait_out);
			chk_wr(0, 16'h00D0, 8'h44);
		end
	endtask

	initial begin
		bad_count = 0;
		n_checks = 0;
		reset_n_in = 1'b0;
		irq_n_in = 1'b1;
		periph_irq_in = 1'b0;
		repeat (16) @(posedge clk_sys_in);
		t_mul();
		t_modes();
		t_rmw();
		t_bits();
		t_sub();
		t_pin();
		t_halt();
		summarize();
	end

	initial begin
		repeat (40000) @(posedge clk_sys_in);
		bad_count++;
		summarize();
	end
endmodule // testbench
